// ===== hw/branch_pkg.sv
// Shared types and constants for the branch condition and loop unit
package branch_pkg;

  localparam int IP_W = 64;
  localparam int DISP_W = 32;
  localparam int CNT16_W = 16;
  localparam int CNT32_W = 32;
  localparam int CNT64_W = 64;

  // Branch kinds handled by this unit
  typedef enum logic [2:0] {
    OP_JCC,
    OP_JCZ,
    OP_LOOP,
    OP_LOOP_EQ,
    OP_LOOP_NE
  } op_t;

  // Condition codes of the conditional jump family
  typedef enum logic [3:0] {
    CC_O, CC_NO, CC_B, CC_AE, CC_E, CC_NE, CC_BE, CC_A,
    CC_S, CC_NS, CC_P, CC_NP, CC_L, CC_GE, CC_LE, CC_G
  } cc_t;

  // Operand or address size
  typedef enum logic [1:0] {
    SZ_16,
    SZ_32,
    SZ_64
  } size_t;

  typedef struct packed {
    logic done;
    logic taken;
    logic [IP_W-1:0] next_ip;
    logic [CNT64_W-1:0] count;
    logic count_we;
    logic flags_we;
    logic ret_push;
  } state_t;

  localparam state_t STATE_RST = '0;

endpackage

// ===== hw/branch_cond_eval.sv
// Condition code evaluation against the five status flags
`timescale 1ns/1ps
`default_nettype none
module branch_cond_eval (
  // Condition and flags
  input wire branch_pkg::cc_t cc_i,
  input wire logic carry_flag_i,
  input wire logic zero_flag_i,
  input wire logic parity_flag_i,
  input wire logic overflow_flag_i,
  input wire logic sign_flag_i,
  // Result
  output logic met_o
);
  import branch_pkg::*;

  logic lt;

  always_comb begin
    lt = sign_flag_i ^ overflow_flag_i;
    case (cc_i)
      CC_O: met_o = overflow_flag_i;
      CC_NO: met_o = !overflow_flag_i;
      CC_B: met_o = carry_flag_i;
      CC_AE: met_o = !carry_flag_i;
      CC_E: met_o = zero_flag_i;
      CC_NE: met_o = !zero_flag_i;
      CC_BE: met_o = carry_flag_i | zero_flag_i;
      CC_A: met_o = !(carry_flag_i | zero_flag_i);
      CC_S: met_o = sign_flag_i;
      CC_NS: met_o = !sign_flag_i;
      CC_P: met_o = parity_flag_i;
      CC_NP: met_o = !parity_flag_i;
      CC_L: met_o = lt;
      CC_GE: met_o = !lt;
      CC_LE: met_o = lt | zero_flag_i;
      CC_G: met_o = !(lt | zero_flag_i);
      default: met_o = 1'b0;
    endcase
  end

endmodule // branch_cond_eval
`default_nettype wire

// ===== hw/branch_count_step.sv
// Count register zero test and decrement at the selected address size
`timescale 1ns/1ps
`default_nettype none
module branch_count_step #(
  parameter int W = branch_pkg::CNT64_W
) (
  // Count and size
  input wire logic [W-1:0] count_i,
  input wire branch_pkg::size_t asz_i,
  // Results
  output logic [W-1:0] dec_o,
  output logic cur_zero_o,
  output logic dec_zero_o
);
  import branch_pkg::*;

  // Only the selected low part changes; upper bits are kept as they were
  always_comb begin
    dec_o = count_i;
    case (asz_i)
      SZ_16: begin
        dec_o[CNT16_W-1:0] = count_i[CNT16_W-1:0] - 16'h0001;
        cur_zero_o = count_i[CNT16_W-1:0] == '0;
        dec_zero_o = dec_o[CNT16_W-1:0] == '0;
      end
      SZ_32: begin
        dec_o[CNT32_W-1:0] = count_i[CNT32_W-1:0] - 32'h0000_0001;
        cur_zero_o = count_i[CNT32_W-1:0] == '0;
        dec_zero_o = dec_o[CNT32_W-1:0] == '0;
      end
      default: begin
        dec_o = count_i - W'(1);
        cur_zero_o = count_i == '0;
        dec_zero_o = dec_o == '0;
      end
    endcase
  end

endmodule // branch_count_step
`default_nettype wire

// ===== hw/branch_condition_loop_unit.sv
// Conditional branch, count-zero branch and count-down loop resolution
//
// Notes on behaviour
// - Taken branch goes to target, else next instruction; no return address.
// - Single-flag codes test carry, zero, parity, overflow or sign.
// - Above: taken when carry and zero are both clear.
// - Above-or-equal needs carry clear; below needs carry set.
// - Below-or-equal: taken when carry or zero is set.
// - Greater: zero clear and sign equals overflow.
// - Greater-or-equal: sign xor overflow is zero.
// - Less: sign xor overflow is one.
// - Less-or-equal: zero set or sign differs from overflow.
// - Count-zero branch tests count register, not flags.
// - Target is pointer plus signed displacement, near only.
// - Loop decrements count first, branches if result non-zero.
// - Zero count wraps to all ones; no special case.
// - Sixteen-bit address size uses the sixteen-bit count.
// - Loop-while-equal branches if count non-zero and zero flag set.
// - Loop-while-unequal branches if count non-zero and zero flag clear.
// - In 64-bit mode near branches use full 64-bit pointer.
// - In 64-bit mode pointer truncation width is 64 regardless of prefix.
// - Displacement stays 32 bits, sign-extended; address size not forced.
// - 64-bit mode address size defaults 64, prefix gives 32.
`timescale 1ns/1ps
`default_nettype none
module branch_condition_loop_unit (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Branch request
  input wire logic req_valid_i,
  input wire branch_pkg::op_t op_i,
  input wire branch_pkg::cc_t cc_i,
  input wire logic [branch_pkg::DISP_W-1:0] disp_i,
  input wire logic [branch_pkg::IP_W-1:0] ip_next_i,
  // Architectural state
  input wire logic carry_flag_i,
  input wire logic zero_flag_i,
  input wire logic parity_flag_i,
  input wire logic overflow_flag_i,
  input wire logic sign_flag_i,
  input wire logic [branch_pkg::CNT64_W-1:0] count_i,
  // Mode
  input wire logic long_mode_i,
  input wire logic code_32_i,
  input wire logic addr_ovr_i,
  input wire logic oper_ovr_i,
  // Result
  output logic done_o,
  output logic taken_o,
  output logic [branch_pkg::IP_W-1:0] next_ip_o,
  output logic [branch_pkg::CNT64_W-1:0] count_o,
  output logic count_we_o,
  output logic flags_we_o,
  output logic ret_push_o
);
  import branch_pkg::*;

  state_t st_r;
  state_t st_nxt;
  logic met;
  logic [CNT64_W-1:0] cnt_dec;
  logic cur_zero;
  logic dec_zero;
  size_t asz;
  size_t osz;
  logic [IP_W-1:0] target;

  // Size from mode, default and prefix; long mode may force 64
  function automatic size_t size_sel(input logic lm, input logic def32,
                                     input logic ovr, input logic force64);
    if (lm)
      return (force64 || !ovr) ? SZ_64 : SZ_32;
    return (def32 ^ ovr) ? SZ_32 : SZ_16;
  endfunction

  // Pointer truncation to operand width
  function automatic logic [IP_W-1:0] trunc_ip(input logic [IP_W-1:0] ip,
                                               input size_t sz);
    case (sz)
      SZ_16: return {{(IP_W-CNT16_W){1'b0}}, ip[CNT16_W-1:0]};
      SZ_32: return {{(IP_W-CNT32_W){1'b0}}, ip[CNT32_W-1:0]};
      default: return ip;
    endcase
  endfunction

  assign asz = size_sel(long_mode_i, code_32_i, addr_ovr_i, 1'b0);
  assign osz = size_sel(long_mode_i, code_32_i, oper_ovr_i, 1'b1);
  // Displacement never exceeds 32 bits even in long mode
  assign target = ip_next_i
                + {{(IP_W-DISP_W){disp_i[DISP_W-1]}}, disp_i};

  branch_cond_eval u_cond (
    .cc_i(cc_i),
    .carry_flag_i(carry_flag_i),
    .zero_flag_i(zero_flag_i),
    .parity_flag_i(parity_flag_i),
    .overflow_flag_i(overflow_flag_i),
    .sign_flag_i(sign_flag_i),
    .met_o(met)
  );

  branch_count_step #(.W(CNT64_W)) u_count (
    .count_i(count_i),
    .asz_i(asz),
    .dec_o(cnt_dec),
    .cur_zero_o(cur_zero),
    .dec_zero_o(dec_zero)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.count_we = 1'b0;
    st_nxt.flags_we = 1'b0;
    st_nxt.ret_push = 1'b0;
    if (req_valid_i) begin
      st_nxt.done = 1'b1;
      st_nxt.count = count_i;
      case (op_i)
        OP_JCC: st_nxt.taken = met;
        OP_JCZ: st_nxt.taken = cur_zero;
        OP_LOOP: begin
          st_nxt.taken = !dec_zero;
          st_nxt.count = cnt_dec;
          st_nxt.count_we = 1'b1;
        end
        OP_LOOP_EQ: begin
          st_nxt.taken = !dec_zero && zero_flag_i;
          st_nxt.count = cnt_dec;
          st_nxt.count_we = 1'b1;
        end
        OP_LOOP_NE: begin
          st_nxt.taken = !dec_zero && !zero_flag_i;
          st_nxt.count = cnt_dec;
          st_nxt.count_we = 1'b1;
        end
        default: st_nxt.taken = 1'b0;
      endcase
      // Fall-through also truncated so the pointer stays in range
      st_nxt.next_ip = trunc_ip(st_nxt.taken ? target : ip_next_i,
                                osz);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)
      st_r <= STATE_RST;
    else
      st_r <= st_nxt;
  end

  assign done_o = st_r.done;
  assign taken_o = st_r.taken;
  assign next_ip_o = st_r.next_ip;
  assign count_o = st_r.count;
  assign count_we_o = st_r.count_we;
  assign flags_we_o = st_r.flags_we;
  assign ret_push_o = st_r.ret_push;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_above_cond: assert property (
    req_valid_i && op_i == OP_JCC && cc_i == CC_A
    |=> done_o && taken_o == !($past(carry_flag_i) || $past(zero_flag_i)))
    else $error("above condition wrong");

  a_below_eq: assert property (
    req_valid_i && op_i == OP_JCC && cc_i == CC_BE
    |=> taken_o == ($past(carry_flag_i) || $past(zero_flag_i)))
    else $error("below-or-equal condition wrong");

  a_carry_pair: assert property (
    req_valid_i && op_i == OP_JCC && (cc_i == CC_B || cc_i == CC_AE)
    |=> taken_o == ($past(carry_flag_i) == ($past(cc_i) == CC_B)))
    else $error("carry condition wrong");

  a_single_flag: assert property (
    req_valid_i && op_i == OP_JCC && (cc_i == CC_P || cc_i == CC_NS)
    |=> taken_o == ($past(cc_i) == CC_P ? $past(parity_flag_i)
                                        : !$past(sign_flag_i)))
    else $error("single flag condition wrong");

  a_greater_cond: assert property (
    req_valid_i && op_i == OP_JCC && cc_i == CC_G
    |=> taken_o == (!$past(zero_flag_i)
                    && $past(sign_flag_i) == $past(overflow_flag_i)))
    else $error("greater condition wrong");

  a_signed_lt: assert property (
    req_valid_i && op_i == OP_JCC && (cc_i == CC_L || cc_i == CC_GE)
    |=> taken_o == (($past(sign_flag_i) ^ $past(overflow_flag_i))
                    == ($past(cc_i) == CC_L)))
    else $error("signed less condition wrong");

  a_less_eq: assert property (
    req_valid_i && op_i == OP_JCC && cc_i == CC_LE
    |=> taken_o == ($past(zero_flag_i)
                    || $past(sign_flag_i) != $past(overflow_flag_i)))
    else $error("less-or-equal condition wrong");

  a_count_zero: assert property (
    req_valid_i && op_i == OP_JCZ && !long_mode_i && !code_32_i
    && !addr_ovr_i
    |=> taken_o == ($past(count_i[CNT16_W-1:0]) == '0) && !count_we_o)
    else $error("count-zero test wrong");

  a_loop_wrap: assert property (
    req_valid_i && op_i == OP_LOOP && long_mode_i && addr_ovr_i
    && count_i[CNT32_W-1:0] == '0
    |=> count_we_o && count_o[CNT32_W-1:0] == '1 && taken_o)
    else $error("loop wrap wrong");

  a_loop_eq: assert property (
    req_valid_i && (op_i == OP_LOOP_EQ || op_i == OP_LOOP_NE)
    // Two set low bits keep the decrement non-zero at any address size
    && $countones(count_i[CNT16_W-1:0]) > 1
    |=> taken_o == ($past(zero_flag_i) == ($past(op_i) == OP_LOOP_EQ)))
    else $error("loop zero flag test wrong");

  a_target_sel: assert property (
    req_valid_i && long_mode_i
    |=> next_ip_o == (taken_o ? $past(target) : $past(ip_next_i)))
    else $error("next pointer wrong");

  a_no_side: assert property (
    !flags_we_o && !ret_push_o)
    else $error("flags or return push written");

  // Nothing new may appear on a cycle with no request
  a_done_pulse: assert property (
    !req_valid_i |=> !done_o && !count_we_o)
    else $error("result strobe without request");

  a_result_hold: assert property (
    !req_valid_i
    |=> $stable(taken_o) && $stable(next_ip_o) && $stable(count_o))
    else $error("result changed without request");

  a_undef_op: assert property (
    req_valid_i && op_i > OP_LOOP_NE
    |=> done_o && !taken_o && !count_we_o)
    else $error("undefined branch kind taken");

  a_zero_flag: assert property (
    req_valid_i && op_i == OP_JCC && (cc_i == CC_E || cc_i == CC_NE)
    |=> taken_o == ($past(zero_flag_i) == ($past(cc_i) == CC_E)))
    else $error("zero flag condition wrong");

  a_over_flag: assert property (
    req_valid_i && op_i == OP_JCC && (cc_i == CC_O || cc_i == CC_NO)
    |=> taken_o == ($past(overflow_flag_i) == ($past(cc_i) == CC_O)))
    else $error("overflow flag condition wrong");

  a_sign_parity: assert property (
    req_valid_i && op_i == OP_JCC && (cc_i == CC_S || cc_i == CC_NP)
    |=> taken_o == ($past(cc_i) == CC_S ? $past(sign_flag_i)
                                        : !$past(parity_flag_i)))
    else $error("sign or parity condition wrong");

  a_count_copy: assert property (
    req_valid_i && (op_i == OP_JCC || op_i == OP_JCZ)
    |=> count_o == $past(count_i) && !count_we_o)
    else $error("count altered by a jump");

  a_jcz_wide: assert property (
    req_valid_i && op_i == OP_JCZ && long_mode_i && !addr_ovr_i
    |=> taken_o == ($past(count_i) == '0))
    else $error("64-bit count-zero test wrong");

  a_loop_write: assert property (
    req_valid_i && (op_i == OP_LOOP || op_i == OP_LOOP_EQ
                    || op_i == OP_LOOP_NE)
    |=> done_o && count_we_o)
    else $error("loop did not write the count");

  a_loop_full: assert property (
    req_valid_i && op_i == OP_LOOP && long_mode_i && !addr_ovr_i
    |=> count_o == $past(count_i) - 64'h1
        && taken_o == ($past(count_i) != 64'h1))
    else $error("full width loop wrong");

  a_loop_short: assert property (
    req_valid_i && op_i == OP_LOOP && !long_mode_i
    && code_32_i == addr_ovr_i
    |=> count_o[CNT16_W-1:0] == $past(count_i[CNT16_W-1:0]) - 16'h0001
        && count_o[CNT64_W-1:CNT16_W]
           == $past(count_i[CNT64_W-1:CNT16_W])
        && taken_o == ($past(count_i[CNT16_W-1:0]) != 16'h0001))
    else $error("16-bit loop wrong");

  a_trunc_narrow: assert property (
    req_valid_i && !long_mode_i && code_32_i == oper_ovr_i
    |=> next_ip_o[IP_W-1:CNT16_W] == '0)
    else $error("16-bit pointer not truncated");

  c_loop_taken: cover property (
    req_valid_i && op_i == OP_LOOP ##1 taken_o);
  c_loop_exit: cover property (
    req_valid_i && op_i == OP_LOOP_NE ##1 done_o && !taken_o);
  c_jcc_back: cover property (
    req_valid_i && op_i == OP_JCC && disp_i[DISP_W-1] ##1 taken_o);
  c_jcz_taken: cover property (
    req_valid_i && op_i == OP_JCZ ##1 taken_o);
  c_loop_wrap: cover property (
    req_valid_i && op_i == OP_LOOP && count_i == '0 ##1 taken_o);

endmodule // branch_condition_loop_unit
`default_nettype wire

// ===== testbench/test_branch_condition_loop_unit.sv
// Self-checking bench for the branch condition and loop unit
`timescale 1ns/1ps
`default_nettype none
module test_branch_condition_loop_unit;
  import branch_pkg::*;
  typedef struct packed {
    op_t op;
    logic [4:0] fl;
    logic [63:0] cnt;
    logic [3:0] md;
    logic tk;
    logic [63:0] ecnt;
  } row_t;
  // Flags are {carry, zero, parity, overflow, sign}
  // Mode is {long, code_32, addr_ovr, oper_ovr}
  localparam row_t rows [15] = '{
    '{OP_JCZ, 5'h00, 64'h0, 4'h8, 1'b1, 64'h0},
    '{OP_JCZ, 5'h08, 64'h0000_0001_0000_0000, 4'h8, 1'b0,
      64'h0000_0001_0000_0000},
    '{OP_JCZ, 5'h00, 64'h0000_0001_0000_0000, 4'hA, 1'b1,
      64'h0000_0001_0000_0000},
    '{OP_JCZ, 5'h00, 64'h0000_0000_0001_0000, 4'h0, 1'b1,
      64'h0000_0000_0001_0000},
    '{OP_LOOP, 5'h00, 64'h5, 4'h8, 1'b1, 64'h4},
    '{OP_LOOP, 5'h08, 64'h1, 4'h8, 1'b0, 64'h0},
    '{OP_LOOP, 5'h00, 64'h0, 4'hA, 1'b1, 64'h0000_0000_FFFF_FFFF},
    '{OP_LOOP, 5'h00, 64'h0000_0000_AAAA_0000, 4'h0, 1'b1,
      64'h0000_0000_AAAA_FFFF},
    '{OP_LOOP, 5'h00, 64'h0000_0001_0000_0000, 4'h4, 1'b1,
      64'h0000_0001_FFFF_FFFF},
    '{OP_LOOP, 5'h00, 64'h0000_0000_0001_0000, 4'h6, 1'b1,
      64'h0000_0000_0001_FFFF},
    '{OP_LOOP_EQ, 5'h08, 64'h3, 4'h8, 1'b1, 64'h2},
    '{OP_LOOP_EQ, 5'h00, 64'h3, 4'h8, 1'b0, 64'h2},
    '{OP_LOOP_EQ, 5'h08, 64'h1, 4'h8, 1'b0, 64'h0},
    '{OP_LOOP_NE, 5'h00, 64'h3, 4'h8, 1'b1, 64'h2},
    '{OP_LOOP_NE, 5'h08, 64'h3, 4'h8, 1'b0, 64'h2}
  };
  localparam logic [63:0] fall = 64'h0000_0000_0000_1000;
  localparam logic [63:0] tgt = 64'h0000_0000_0000_0FF0;
  logic clock_i, rst_n_i, req_valid_i;
  op_t op_i;
  cc_t cc_i;
  logic [31:0] disp_i;
  logic [63:0] ip_next_i, count_i, next_ip_o, count_o;
  logic carry_flag_i, zero_flag_i, parity_flag_i, overflow_flag_i;
  logic sign_flag_i, long_mode_i, code_32_i, addr_ovr_i, oper_ovr_i;
  logic done_o, taken_o, count_we_o, flags_we_o, ret_push_o;
  int err_count, compares, cycles;

  branch_condition_loop_unit dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .op_i(op_i), .cc_i(cc_i), .disp_i(disp_i), .ip_next_i(ip_next_i),
    .carry_flag_i(carry_flag_i), .zero_flag_i(zero_flag_i),
    .parity_flag_i(parity_flag_i), .overflow_flag_i(overflow_flag_i),
    .sign_flag_i(sign_flag_i), .count_i(count_i),
    .long_mode_i(long_mode_i), .code_32_i(code_32_i),
    .addr_ovr_i(addr_ovr_i), .oper_ovr_i(oper_ovr_i),
    .done_o(done_o), .taken_o(taken_o), .next_ip_o(next_ip_o),
    .count_o(count_o), .count_we_o(count_we_o),
    .flags_we_o(flags_we_o), .ret_push_o(ret_push_o));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // Written straight from the condition table, independent of the design
  function automatic logic cc_ref(input cc_t c, input logic [4:0] f);
    logic cf, zf, pf, of, sf;
    {cf, zf, pf, of, sf} = f;
    case (c)
      CC_O: return of;
      CC_NO: return !of;
      CC_B: return cf;
      CC_AE: return !cf;
      CC_E: return zf;
      CC_NE: return !zf;
      CC_BE: return cf | zf;
      CC_A: return !(cf | zf);
      CC_S: return sf;
      CC_NS: return !sf;
      CC_P: return pf;
      CC_NP: return !pf;
      CC_L: return sf ^ of;
      CC_GE: return !(sf ^ of);
      CC_LE: return (sf ^ of) | zf;
      default: return !((sf ^ of) | zf);
    endcase
  endfunction

  task automatic cb(input string n, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %b got %b", n, e, s);
    end
  endtask

  task automatic cw(input string n, input logic [63:0] e,
                    input logic [63:0] s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask

  // Inputs change at the falling edge; the answer is read one cycle later
  task automatic send(input op_t op, input cc_t cc, input logic [4:0] fl,
                      input logic [63:0] cnt, input logic [3:0] md,
                      input logic [63:0] ip, input logic [31:0] d);
    req_valid_i = 1'b1;
    op_i = op;
    cc_i = cc;
    {carry_flag_i, zero_flag_i, parity_flag_i, overflow_flag_i,
     sign_flag_i} = fl;
    count_i = cnt;
    {long_mode_i, code_32_i, addr_ovr_i, oper_ovr_i} = md;
    ip_next_i = ip;
    disp_i = d;
    @(negedge clock_i);
  endtask

  task automatic chk(input logic tk, input logic [63:0] ip,
                     input logic [63:0] cnt, input logic we);
    cb("done", 1'b1, done_o);
    cb("taken", tk, taken_o);
    cw("next_ip", ip, next_ip_o);
    cw("count", cnt, count_o);
    cb("count_we", we, count_we_o);
    cb("flags_we", 1'b0, flags_we_o);
    cb("ret_push", 1'b0, ret_push_o);
  endtask

  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // About 550 cycles are needed; the ceiling leaves ample margin
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      $display("timeout");
      tally_and_finish();
    end
  end

  initial begin
    row_t r;
    logic t;
    rst_n_i = 1'b0;
    send(OP_JCC, CC_O, 5'h00, 64'h0, 4'h8, fall, 32'h0);
    req_valid_i = 1'b0;
    repeat (15) @(negedge clock_i);
    cb("done", 1'b0, done_o);
    cw("next_ip", 64'h0, next_ip_o);
    rst_n_i = 1'b1;
    $display("test reset done");
    for (int i = 0; i < 15; i++) begin
      r = rows[i];
      send(r.op, CC_O, r.fl, r.cnt, r.md, fall, 32'hFFFF_FFF0);
      chk(r.tk, r.tk ? tgt : fall, r.ecnt, r.op != OP_JCZ);
    end
    $display("test rows done");
    for (int c = 0; c < 16; c++) begin
      for (int f = 0; f < 32; f++) begin
        t = cc_ref(cc_t'(c), 5'(f));
        send(OP_JCC, cc_t'(c), 5'(f), 64'h7, 4'h8, fall, 32'hFFFF_FFF0);
        chk(t, t ? tgt : fall, 64'h7, 1'b0);
      end
    end
    $display("test conditions done");
    send(op_t'(3'h7), CC_O, 5'h1F, 64'h9, 4'h8, fall, 32'hFFFF_FFF0);
    chk(1'b0, fall, 64'h9, 1'b0);
    send(OP_JCC, CC_E, 5'h08, 64'h0, 4'h9, 64'h0000_7FFF_FFFF_FFF0,
         32'h8000_0000);
    chk(1'b1, 64'h0000_7FFF_7FFF_FFF0, 64'h0, 1'b0);
    send(OP_JCC, CC_NE, 5'h00, 64'h0, 4'h8, 64'h0000_0000_FFFF_FFF0,
         32'h0000_0020);
    chk(1'b1, 64'h0000_0001_0000_0010, 64'h0, 1'b0);
    send(OP_JCC, CC_E, 5'h00, 64'h0, 4'h5, 64'h0000_0000_0001_0010,
         32'h0);
    chk(1'b0, 64'h0000_0000_0000_0010, 64'h0, 1'b0);
    send(OP_JCC, CC_NE, 5'h00, 64'h0, 4'h4, 64'h0000_0000_FFFF_FFF0,
         32'h0000_0020);
    chk(1'b1, 64'h0000_0000_0000_0010, 64'h0, 1'b0);
    req_valid_i = 1'b0;
    @(negedge clock_i);
    cb("done", 1'b0, done_o);
    cb("taken", 1'b1, taken_o);
    $display("test widths done");
    // Reset drops between rising edges to prove it does not wait for clock
    rst_n_i = 1'b0;
    #1 cb("taken", 1'b0, taken_o);
    cw("next_ip", 64'h0, next_ip_o);
    @(negedge clock_i);
    cb("done", 1'b0, done_o);
    rst_n_i = 1'b1;
    send(OP_LOOP, CC_O, 5'h00, 64'h5, 4'h8, fall, 32'hFFFF_FFF0);
    chk(1'b1, tgt, 64'h4, 1'b1);
    req_valid_i = 1'b0;
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule // test_branch_condition_loop_unit
`default_nettype wire
